// file: common/sensor_cfg_pkg.sv
// constants, reset values and carriers for the sensor configuration bank
package sensor_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam int        ADDR_W        = 12;
    localparam int        IDX_W         = 8;
    localparam int        REG_W         = 16;
    localparam logic [7:0] IDX_PUMP      = 8'h48;
    localparam logic [7:0] IDX_SPARE_A   = 8'h50;
    localparam logic [7:0] IDX_SPARE_B   = 8'h51;
    localparam logic [7:0] IDX_THERM_CTL = 8'h60;
    localparam logic [7:0] IDX_THERM_RD  = 8'h61;
    localparam logic [7:0] IDX_SER_PWR   = 8'h70;
    localparam logic [7:0] IDX_BLACK     = 8'h80;
    localparam logic [7:0] IDX_DPATH     = 8'h81;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0] RST_PUMP      = 16'h1200;
    localparam logic [15:0] RST_SPARE_A   = 16'h0000;
    localparam logic [15:0] RST_SPARE_B   = 16'h0000;
    localparam logic [15:0] RST_THERM_CTL = 16'h0000;
    localparam logic [7:0]  RST_THERM_RD  = 8'h00;
    localparam logic [15:0] RST_SER_PWR   = 16'h0000;
    localparam logic [15:0] RST_BLACK     = 16'h4008;
    localparam logic [15:0] RST_DPATH     = 16'hc001;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int PUMP_PD_EN_BIT   = 0;
    localparam int PUMP_FD_EN_BIT   = 1;
    localparam int PUMP_PD_TRIM_LSB = 8;
    localparam int PUMP_FD_TRIM_LSB = 12;
    localparam int TRIM_W           = 3;
    localparam int THERM_EN_BIT     = 0;
    localparam int THERM_W          = 8;
    localparam int SER_CLK_BIT      = 0;
    localparam int SER_SYNC_BIT     = 1;
    localparam int SER_DATA_BIT     = 2;
    localparam int BLK_LEVEL_LSB    = 0;
    localparam int BLK_LEVEL_W      = 8;
    localparam int BLK_EXP_LSB      = 8;
    localparam int BLK_EXP_W        = 3;
    localparam int BLK_SEED_BIT     = 15;

    localparam logic [15:0] CRC_ALL_ZERO = 16'h0000;
    localparam logic [15:0] CRC_ALL_ONE  = 16'hffff;
    localparam logic [7:0]  ONE_SAMPLE   = 8'h01;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [2:0] fd_trim;
        logic [2:0] pd_trim;
        logic       fd_en;
        logic       pd_en;
    } pump_cfg_s;

    typedef struct packed {
        logic data_on;
        logic sync_on;
        logic clk_on;
    } serial_pwr_s;

    typedef struct packed {
        logic [15:0] crc_init;
        logic [7:0]  sample_count;
        logic [7:0]  target;
    } black_cal_s;

endpackage

// file: rtl/cfg_word.sv
// one 16-bit configuration word with byte-lane writes
`timescale 1ns/1ps
module cfg_word
#(
    parameter logic [15:0] RST = 16'h0000
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // write side
    input  wire logic [1:0]  be,
    input  wire logic [15:0] wdata,
    // stored value
    output logic      [15:0] q
);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= RST;
        end
        else
        begin
            if (be[0])
            begin
                q[7:0] <= wdata[7:0];
            end
            if (be[1])
            begin
                q[15:8] <= wdata[15:8];
            end
        end
    end

endmodule

// file: rtl/sensor_cfg_bank.sv
// configuration bank for charge pump, thermal diode, serial power and black calibration
//
// Overview of operation
// - bits 0,1 enable transfer and diffusion pumps
// - pump trims in 10:8 and 14:12
// - diode on only while enabled; 8-bit reading
// - serial clock output powered only while bit0
// - sync channel powered only while bit1
// - bit2 powers all four data channels
// - low byte sets target black level
// - average two to the exponent samples
// - bit 15 picks crc start zeros or ones
`timescale 1ns/1ps
module sensor_cfg_bank
    import sensor_cfg_pkg::*;
(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic                   pready,
    output logic      [31:0]       prdata,
    output logic                   pslverr,
    // thermal diode
    input  wire logic [THERM_W-1:0] temp_code,
    output logic                   therm_diode_on,
    // analog and serializer controls
    output pump_cfg_s              pump_cfg,
    output serial_pwr_s            serial_pwr,
    output black_cal_s             black_cal,
    output logic      [REG_W-1:0]  data_path_cfg
);

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic [IDX_W-1:0]  idx;
    logic              aligned;
    logic              sel_pump;
    logic              sel_spare_a;
    logic              sel_spare_b;
    logic              sel_therm_ctl;
    logic              sel_therm_rd;
    logic              sel_ser_pwr;
    logic              sel_black;
    logic              sel_dpath;
    logic              hit;
    logic [REG_W-1:0]  rd_mux;
    logic              setup;
    logic              wr_fire;
    logic [1:0]        be;

    logic [REG_W-1:0]  pump_word;
    logic [REG_W-1:0]  spare_a_word;
    logic [REG_W-1:0]  spare_b_word;
    logic [REG_W-1:0]  therm_ctl_word;
    logic [REG_W-1:0]  ser_pwr_word;
    logic [REG_W-1:0]  black_word;
    logic [REG_W-1:0]  dpath_word;
    logic [THERM_W-1:0] therm_rd_q;

    logic              pready_q;
    logic [31:0]       prdata_q;
    logic              pslverr_q;
    pump_cfg_s         pump_cfg_q;
    serial_pwr_s       serial_pwr_q;
    black_cal_s        black_cal_q;
    logic [REG_W-1:0]  data_path_q;
    logic              therm_on_q;

    assign idx     = paddr[IDX_W+1:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:IDX_W+2] == '0);

    always_comb
    begin
        sel_pump      = 1'b0;
        sel_spare_a   = 1'b0;
        sel_spare_b   = 1'b0;
        sel_therm_ctl = 1'b0;
        sel_therm_rd  = 1'b0;
        sel_ser_pwr   = 1'b0;
        sel_black     = 1'b0;
        sel_dpath     = 1'b0;
        rd_mux        = '0;
        if (!aligned)
        begin
            rd_mux = '0;
        end
        else if (idx == IDX_PUMP)
        begin
            sel_pump = 1'b1;
            rd_mux   = pump_word;
        end
        else if (idx == IDX_SPARE_A)
        begin
            sel_spare_a = 1'b1;
            rd_mux      = spare_a_word;
        end
        else if (idx == IDX_SPARE_B)
        begin
            sel_spare_b = 1'b1;
            rd_mux      = spare_b_word;
        end
        else if (idx == IDX_THERM_CTL)
        begin
            sel_therm_ctl = 1'b1;
            rd_mux        = therm_ctl_word;
        end
        else if (idx == IDX_THERM_RD)
        begin
            sel_therm_rd = 1'b1;
            rd_mux       = {{(REG_W-THERM_W){1'b0}}, therm_rd_q};
        end
        else if (idx == IDX_SER_PWR)
        begin
            sel_ser_pwr = 1'b1;
            rd_mux      = ser_pwr_word;
        end
        else if (idx == IDX_BLACK)
        begin
            sel_black = 1'b1;
            rd_mux    = black_word;
        end
        else if (idx == IDX_DPATH)
        begin
            sel_dpath = 1'b1;
            rd_mux    = dpath_word;
        end
    end

    assign hit     = sel_pump | sel_spare_a | sel_spare_b | sel_therm_ctl | sel_therm_rd
                   | sel_ser_pwr | sel_black | sel_dpath;
    assign setup   = psel & ~penable;
    // writes land only at the completing edge; unmapped writes are dropped
    assign wr_fire = psel & penable & pready_q & pwrite & hit;
    assign be      = wr_fire ? pstrb[1:0] : 2'b00;

    ////////////////////////////////////////////////////////////////////////////
    // apb answer: zero wait states, reply prepared in the setup cycle

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= setup;
            pslverr_q <= setup & ~hit;
            if (setup && !pwrite)
            begin
                prdata_q <= {16'h0000, rd_mux};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stored words; reserved bits are kept as written

    cfg_word #(.RST(RST_PUMP)) u_pump
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_pump ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (pump_word)
    );

    cfg_word #(.RST(RST_SPARE_A)) u_spare_a
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_spare_a ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (spare_a_word)
    );

    cfg_word #(.RST(RST_SPARE_B)) u_spare_b
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_spare_b ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (spare_b_word)
    );

    cfg_word #(.RST(RST_THERM_CTL)) u_therm_ctl
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_therm_ctl ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (therm_ctl_word)
    );

    cfg_word #(.RST(RST_SER_PWR)) u_ser_pwr
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_ser_pwr ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (ser_pwr_word)
    );

    cfg_word #(.RST(RST_BLACK)) u_black
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_black ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (black_word)
    );

    cfg_word #(.RST(RST_DPATH)) u_dpath
    (
        .pclk    (pclk),
        .presetn (presetn),
        .be      (sel_dpath ? be : 2'b00),
        .wdata   (pwdata[15:0]),
        .q       (dpath_word)
    );

    ////////////////////////////////////////////////////////////////////////////
    // thermal readout: held while the diode is off, so the last value survives

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            therm_on_q <= 1'b0;
            therm_rd_q <= RST_THERM_RD;
        end
        else
        begin
            therm_on_q <= therm_ctl_word[THERM_EN_BIT];
            if (therm_on_q)
            begin
                therm_rd_q <= temp_code;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control outputs, one register stage behind the stored words

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pump_cfg_q <= '0;
        end
        else
        begin
            pump_cfg_q.pd_en   <= pump_word[PUMP_PD_EN_BIT];
            pump_cfg_q.fd_en   <= pump_word[PUMP_FD_EN_BIT];
            pump_cfg_q.pd_trim <= pump_word[PUMP_PD_TRIM_LSB +: TRIM_W];
            pump_cfg_q.fd_trim <= pump_word[PUMP_FD_TRIM_LSB +: TRIM_W];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            serial_pwr_q <= '0;
        end
        else
        begin
            serial_pwr_q.clk_on  <= ser_pwr_word[SER_CLK_BIT];
            serial_pwr_q.sync_on <= ser_pwr_word[SER_SYNC_BIT];
            serial_pwr_q.data_on <= ser_pwr_word[SER_DATA_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            black_cal_q <= '0;
            data_path_q <= RST_DPATH;
        end
        else
        begin
            black_cal_q.target       <= black_word[BLK_LEVEL_LSB +: BLK_LEVEL_W];
            black_cal_q.sample_count <= ONE_SAMPLE << black_word[BLK_EXP_LSB +: BLK_EXP_W];
            black_cal_q.crc_init     <= black_word[BLK_SEED_BIT] ? CRC_ALL_ONE : CRC_ALL_ZERO;
            data_path_q              <= dpath_word;
        end
    end

    assign pready         = pready_q;
    assign prdata         = prdata_q;
    assign pslverr        = pslverr_q;
    assign therm_diode_on = therm_on_q;
    assign pump_cfg       = pump_cfg_q;
    assign serial_pwr     = serial_pwr_q;
    assign black_cal      = black_cal_q;
    assign data_path_cfg  = data_path_q;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_pump_enable;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && sel_pump && pstrb[0])
        |=> ##1 (pump_cfg.pd_en == $past(pwdata[0], 2)) && (pump_cfg.fd_en == $past(pwdata[1], 2));
    endproperty
    a_pump_enable : assert property (p_pump_enable) else $error("pump enable not applied");

    property p_pump_trim;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && sel_pump && pstrb[1])
        |=> ##1 (pump_cfg.pd_trim == $past(pwdata[10:8], 2)) && (pump_cfg.fd_trim == $past(pwdata[14:12], 2));
    endproperty
    a_pump_trim : assert property (p_pump_trim) else $error("pump trim not applied");

    property p_therm_hold;
        @(posedge pclk) disable iff (!presetn)
        !therm_diode_on |=> $stable(therm_rd_q);
    endproperty
    a_therm_hold : assert property (p_therm_hold) else $error("reading moved with diode off");

    property p_therm_track;
        @(posedge pclk) disable iff (!presetn)
        therm_diode_on |=> (therm_rd_q == $past(temp_code));
    endproperty
    a_therm_track : assert property (p_therm_track) else $error("reading not sampled");

    property p_ser_clk;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && sel_ser_pwr && pstrb[0]) |=> ##1 (serial_pwr.clk_on == $past(pwdata[0], 2));
    endproperty
    a_ser_clk : assert property (p_ser_clk) else $error("clock output power wrong");

    property p_ser_sync;
        @(posedge pclk) disable iff (!presetn)
        !ser_pwr_word[SER_SYNC_BIT] |=> !serial_pwr.sync_on;
    endproperty
    a_ser_sync : assert property (p_ser_sync) else $error("sync channel powered while off");

    property p_ser_data;
        @(posedge pclk) disable iff (!presetn)
        $rose(ser_pwr_word[SER_DATA_BIT])
        |=> serial_pwr.data_on ##1 (serial_pwr.data_on == $past(ser_pwr_word[SER_DATA_BIT]));
    endproperty
    a_ser_data : assert property (p_ser_data) else $error("data channels power wrong");

    property p_black_target;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && sel_black && pstrb[0]) |=> ##1 (black_cal.target == $past(pwdata[7:0], 2));
    endproperty
    a_black_target : assert property (p_black_target) else $error("black target wrong");

    property p_black_count;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (black_cal.sample_count == (ONE_SAMPLE << $past(black_word[BLK_EXP_LSB +: BLK_EXP_W])));
    endproperty
    a_black_count : assert property (p_black_count) else $error("sample count wrong");

    property p_crc_seed;
        @(posedge pclk) disable iff (!presetn)
        presetn |=> (black_cal.crc_init == ($past(black_word[BLK_SEED_BIT]) ? CRC_ALL_ONE : CRC_ALL_ZERO));
    endproperty
    a_crc_seed : assert property (p_crc_seed) else $error("crc seed wrong");

    ////////////////////////////////////////////////////////////////////////////
    // covers

    c_pump_write : cover property (@(posedge pclk) disable iff (!presetn) wr_fire && sel_pump);
    c_therm_read : cover property (@(posedge pclk) disable iff (!presetn)
        psel && penable && pready && !pwrite && sel_therm_rd && prdata != 32'h0000_0000);
    c_unmapped   : cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
    c_ser_all_on : cover property (@(posedge pclk) disable iff (!presetn)
        serial_pwr.clk_on && serial_pwr.sync_on && serial_pwr.data_on);

endmodule

// file: tb/sensor_cfg_bank_tb_top.sv
// self-checking bench for the sensor configuration bank
`timescale 1ns/1ps
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end
module sensor_cfg_bank_tb_top
    import sensor_cfg_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////////
    logic              pclk      = 1'b0;
    logic              presetn   = 1'b0;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [ADDR_W-1:0] paddr     = '0;
    logic [31:0]       pwdata    = '0;
    logic [3:0]        pstrb     = 4'h0;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [7:0]        temp_code = 8'h00;
    logic              therm_diode_on;
    pump_cfg_s         pump_cfg;
    serial_pwr_s       serial_pwr;
    black_cal_s        black_cal;
    logic [15:0]       data_path_cfg;
    int                num_errors  = 0;
    int                comparisons = 0;
    int                cycles      = 0;
    logic              last_err;
    logic [31:0]       rv;

    sensor_cfg_bank dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .temp_code(temp_code), .therm_diode_on(therm_diode_on), .pump_cfg(pump_cfg),
        .serial_pwr(serial_pwr), .black_cal(black_cal), .data_path_cfg(data_path_cfg));

    always #5 pclk = ~pclk;

    ////////////////////////////////////////////////////////////////////////////
    // hang guard; the full run needs well under a thousand cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles >= 5000)
        begin
            num_errors++;
            stop_test();
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] r);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // no local limit: only the hang guard ends a stuck access
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] dummy;
        apb(1'b1, a, {16'h0000, d}, 4'hf, dummy);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0000_0000, 4'h0, r);
    endtask

    // outputs trail the stored word by one clock
    task automatic settle();
        repeat (3) @(posedge pclk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_reset();
        #1;
        `CHECK(pump_cfg, {3'h1, 3'h2, 1'b0, 1'b0})
        `CHECK(serial_pwr, 3'h0)
        `CHECK(therm_diode_on, 1'b0)
        `CHECK(black_cal, {CRC_ALL_ZERO, ONE_SAMPLE, 8'h08})
        `CHECK(data_path_cfg, RST_DPATH)
        rd(12'h120, rv); `CHECK(rv, {16'h0000, RST_PUMP})
        rd(12'h180, rv); `CHECK(rv, {16'h0000, RST_THERM_CTL})
        rd(12'h184, rv); `CHECK(rv, 32'h0000_0000)
        rd(12'h1c0, rv); `CHECK(rv, {16'h0000, RST_SER_PWR})
        rd(12'h200, rv); `CHECK(rv, {16'h0000, RST_BLACK})
        rd(12'h204, rv); `CHECK(rv, {16'h0000, RST_DPATH})
        $display("test reset done");
    endtask

    task automatic test_pump();
        logic [31:0] dummy;
        wr(12'h120, 16'h5603);
        settle();
        `CHECK(pump_cfg, {3'h5, 3'h6, 1'b1, 1'b1})
        wr(12'h120, 16'h0001);
        settle();
        `CHECK(pump_cfg, {3'h0, 3'h0, 1'b0, 1'b1})
        wr(12'h120, 16'h0002);
        settle();
        `CHECK(pump_cfg, {3'h0, 3'h0, 1'b1, 1'b0})
        // upper lane only: enables must survive
        apb(1'b1, 12'h120, 32'h0000_3400, 4'b0010, dummy);
        rd(12'h120, rv); `CHECK(rv, 32'h0000_3402)
        settle();
        `CHECK(pump_cfg, {3'h3, 3'h4, 1'b1, 1'b0})
        $display("test pump done");
    endtask

    task automatic test_thermal();
        temp_code <= 8'h5a;
        wr(12'h180, 16'h0001);
        settle();
        `CHECK(therm_diode_on, 1'b1)
        rd(12'h184, rv); `CHECK(rv, 32'h0000_005a)
        wr(12'h180, 16'h0000);
        settle();
        `CHECK(therm_diode_on, 1'b0)
        temp_code <= 8'h33;
        wr(12'h184, 16'h00ff);
        `CHECK(last_err, 1'b0)
        rd(12'h184, rv); `CHECK(rv, 32'h0000_005a)
        $display("test thermal done");
    endtask

    task automatic test_serial();
        for (int v = 0; v < 8; v++)
        begin
            wr(12'h1c0, 16'(v));
            settle();
            `CHECK(serial_pwr.clk_on, v[0])
            `CHECK(serial_pwr.sync_on, v[1])
            `CHECK(serial_pwr.data_on, v[2])
        end
        $display("test serial done");
    endtask

    task automatic test_black();
        logic [7:0] lvl;
        for (int e = 0; e < 8; e++)
        begin
            lvl = 8'hf0 + 8'(e);
            wr(12'h200, {e[0], 4'h8, e[2:0], lvl});
            settle();
            `CHECK(black_cal.target, lvl)
            `CHECK(black_cal.sample_count, 8'(1 << e))
            `CHECK(black_cal.crc_init, (e[0] ? CRC_ALL_ONE : CRC_ALL_ZERO))
        end
        $display("test black done");
    endtask

    task automatic test_decode();
        wr(12'h140, RST_SPARE_A);
        wr(12'h144, RST_SPARE_B);
        wr(12'h124, 16'hffff);
        `CHECK(last_err, 1'b1)
        rd(12'h122, rv); `CHECK(last_err, 1'b1)
        rd(12'h3fc, rv); `CHECK(rv, 32'h0000_0000)
        // a refused write must not alias onto a neighbour
        rd(12'h120, rv); `CHECK(rv, 32'h0000_3402)
        `CHECK(last_err, 1'b0)
        wr(12'h204, 16'h4001);
        settle();
        `CHECK(data_path_cfg, 16'h4001)
        $display("test decode done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_pump();
        test_thermal();
        test_serial();
        test_black();
        test_decode();
        stop_test();
    end
endmodule
